/* File: rtl/adc_ctrl_pkg.sv */
package adc_ctrl_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned PCLK_MHZ           = 40;
  localparam int unsigned WAKE_SLOW_US       = 50;
  localparam int unsigned WAKE_BUF_LVDS_NS   = 500;
  localparam int unsigned WAKE_BUF_CMOS_NS   = 200;
  localparam int unsigned CLK_STOP_MSPS      = 1;
  // Nanosecond times round down to whole pclk cycles
  localparam int unsigned WAKE_SLOW_CYC      = WAKE_SLOW_US * PCLK_MHZ;
  localparam int unsigned WAKE_BUF_LVDS_CYC  =
    (WAKE_BUF_LVDS_NS * PCLK_MHZ) / 1000;
  localparam int unsigned WAKE_BUF_CMOS_CYC  =
    (WAKE_BUF_CMOS_NS * PCLK_MHZ) / 1000;
  // Sample period at the stop threshold, in pclk cycles
  localparam int unsigned CLK_STOP_CYC       = PCLK_MHZ / CLK_STOP_MSPS;
  localparam int unsigned WAKE_CNT_W         = 12;
  localparam int unsigned IDLE_CNT_W         = 7;

  // ---------------------------------------------------------------
  // Data path
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W             = 12;
  localparam int unsigned LVDS_PAIRS         = 7;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFS          = 8'h00;
  localparam logic [7:0]  STATUS_OFFS        = 8'h04;
  localparam logic [7:0]  CTRL_RESET         = 8'h01;

  typedef struct packed {
    logic [1:0] drive_boost_field;
    logic       strobe_shift_bit;
    logic       number_format_bit;
    logic       out_style_bit;
    logic       out_buf_off_bit;
    logic       standby_bit;
    logic       pin_ctrl;
  } ctrl_t;

  typedef struct packed {
    logic [1:0] mode;
    logic       lvds_active;
    logic       waking;
    logic       clk_stopped;
    logic       data_valid;
  } status_t;

  // ---------------------------------------------------------------
  // Modes and states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PM_NORMAL, PM_STANDBY, PM_BUF_OFF, PM_GLOBAL_PD
  } pwr_mode_t;

  typedef enum logic [1:0] {WS_RUN, WS_SLEEP, WS_WAKE} wake_state_t;

  // Control levels handed to the sample-clock domain
  typedef struct packed {
    logic out_en;
    logic data_valid;
    logic lvds;
    logic offset_bin;
  } link_ctl_t;

  function automatic pwr_mode_t decode_mode(input logic buf_off,
                                            input logic sleep);
    case ({buf_off, sleep})
      2'b00:   decode_mode = PM_NORMAL;
      2'b01:   decode_mode = PM_STANDBY;
      2'b10:   decode_mode = PM_BUF_OFF;
      default: decode_mode = PM_GLOBAL_PD;
    endcase
  endfunction : decode_mode

endpackage : adc_ctrl_pkg

/* File: rtl/ddr_launch_cell.sv */
`timescale 1ns/1ps

module ddr_launch_cell #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] rise_val,
  input  wire logic [W-1:0] fall_val,
  output logic      [W-1:0] pad_out
);

  // ---------------------------------------------------------------
  // Two-phase launch: high half from rise_q, low half from fall_q
  // ---------------------------------------------------------------
  logic [W-1:0] rise_q;
  logic [W-1:0] fall_hold_q;
  logic [W-1:0] fall_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rise_q      <= '0;
      fall_hold_q <= '0;
    end else begin
      rise_q      <= rise_val;
      fall_hold_q <= fall_val;
    end
  end

  // Held from the rising edge so the low half pairs with the same word
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fall_q <= '0;
    end else begin
      fall_q <= fall_hold_q;
    end
  end

  // Output mux is the pad-side DDR stage
  assign pad_out = clk ? rise_q : fall_q;

endmodule : ddr_launch_cell

/* File: rtl/adc_powerdown_output_ctrl.sv */
// Functional notes
// R1 - Mode from register or from strap pins
// R2 - Two bits decode normal/standby/bufoff/powerdown
// R3 - Global powerdown: core, refs off, outputs tristated; the LVDS strobe pair strobe_out_pos/neg has no enable and keeps toggling
// R4 - Global powerdown exit valid within 50 us
// R5 - Receiver waits about 1 ms for accuracy
// R6 - Standby: core off only, 50 us wake
// R7 - Buffer off tristates; 500/200 ns wake; the LVDS strobe pair strobe_out_pos/neg has no enable and stays driven
// R8 - Sample clock below 1 MSPS: stop, 50 us
// R9 - 12 bits plus strobe; CMOS or LVDS
// R10 - CMOS: one pin per bit, per sample
// R11 - Receiver latches CMOS on strobe rising edge
// R12 - Strobe shift bit delays strobe position
// R13 - Drive boost field raises CMOS drive
// R14 - LVDS: seven DDR data pairs, one strobe pair
// R15 - Even bits rising edge, odd bits falling
// R16 - Twos complement or offset binary selectable
// R17 - Source bit sets precedence; invalid until woken
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps

module adc_powerdown_output_ctrl #(
  parameter int unsigned WAKE_SLOW_CYC_P = adc_ctrl_pkg::WAKE_SLOW_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        buffer_off_pin,
  input  wire logic        sleep_pin,
  input  wire logic        iface_select_pin,
  input  wire logic        sample_clk,
  input  wire logic [11:0] sample_data_in,
  output logic      [11:0] cmos_data_out,
  output logic             cmos_data_oe,
  output logic             sample_strobe_out,
  output logic             sample_strobe_oe,
  output logic      [6:0]  lvds_data_p,
  output logic      [6:0]  lvds_data_n,
  output logic             lvds_data_oe,
  output logic             strobe_out_pos,
  output logic             strobe_out_neg,
  output logic             data_valid_out,
  output logic             core_power_down,
  output logic             ref_power_down,
  output logic             strobe_delay_sel,
  output logic      [1:0]  cmos_drive_strength
);

  // ---------------------------------------------------------------
  // Register-side state
  // ---------------------------------------------------------------
  typedef struct packed {
    adc_ctrl_pkg::ctrl_t                         ctrl;
    logic [31:0]                                 prdata;
    logic                                        pready;
    logic                                        pslverr;
    logic [3:0]                                  sync1;
    logic [3:0]                                  sync2;
    logic                                        tog_prev;
    logic [adc_ctrl_pkg::IDLE_CNT_W-1:0]         idle_cnt;
    logic                                        clk_stopped;
    adc_ctrl_pkg::pwr_mode_t                     mode;
    adc_ctrl_pkg::wake_state_t                   wst;
    logic                                        slow_wake;
    logic [adc_ctrl_pkg::WAKE_CNT_W-1:0]         wake_cnt;
    adc_ctrl_pkg::link_ctl_t                     link;
    logic                                        core_pd;
    logic                                        ref_pd;
    logic                                        strobe_delay;
    logic [1:0]                                  drive;
  } pstate_t;

  // ---------------------------------------------------------------
  // Sample-clock state
  // ---------------------------------------------------------------
  typedef struct packed {
    adc_ctrl_pkg::link_ctl_t s1;
    adc_ctrl_pkg::link_ctl_t s2;
    logic                    tog;
    logic [11:0]             cmos_data;
    logic                    cmos_oe;
    logic                    lvds_oe;
    logic                    valid;
  } sstate_t;

  localparam logic [adc_ctrl_pkg::WAKE_CNT_W-1:0] SLOW_LOAD =
    adc_ctrl_pkg::WAKE_CNT_W'(WAKE_SLOW_CYC_P - 1);
  localparam logic [adc_ctrl_pkg::WAKE_CNT_W-1:0] LVDS_LOAD =
    adc_ctrl_pkg::WAKE_CNT_W'(adc_ctrl_pkg::WAKE_BUF_LVDS_CYC - 1);
  localparam logic [adc_ctrl_pkg::WAKE_CNT_W-1:0] CMOS_LOAD =
    adc_ctrl_pkg::WAKE_CNT_W'(adc_ctrl_pkg::WAKE_BUF_CMOS_CYC - 1);
  localparam logic [adc_ctrl_pkg::IDLE_CNT_W-1:0] STOP_LIMIT =
    adc_ctrl_pkg::IDLE_CNT_W'(adc_ctrl_pkg::CLK_STOP_CYC);

  pstate_t p_q;
  pstate_t p_d;
  sstate_t s_q;
  sstate_t s_d;

  logic [16:0] cell_rise;
  logic [16:0] cell_fall;
  logic [16:0] cell_out;

  // ---------------------------------------------------------------
  // Register-side next state
  // ---------------------------------------------------------------
  always_comb begin
    adc_ctrl_pkg::pwr_mode_t pin_mode;
    adc_ctrl_pkg::pwr_mode_t reg_mode;
    adc_ctrl_pkg::pwr_mode_t req;
    adc_ctrl_pkg::status_t   stat;
    logic                    lvds_sel;
    logic                    fmt_sel;
    logic                    edge_seen;
    logic                    setup;
    logic                    mapped;
    logic                    sleeping;
    logic                    slow_cause;
    pin_mode   = adc_ctrl_pkg::PM_NORMAL;
    reg_mode   = adc_ctrl_pkg::PM_NORMAL;
    req        = adc_ctrl_pkg::PM_NORMAL;
    stat       = '0;
    lvds_sel   = 1'b0;
    fmt_sel    = 1'b0;
    edge_seen  = 1'b0;
    setup      = 1'b0;
    mapped     = 1'b0;
    sleeping   = 1'b0;
    slow_cause = 1'b0;
    p_d        = p_q;

    // Pins and the sample toggle pass two flops first
    p_d.sync1    = {s_q.tog, iface_select_pin, sleep_pin, buffer_off_pin};
    p_d.sync2    = p_q.sync1;
    p_d.tog_prev = p_q.sync2[3];
    edge_seen    = p_q.sync2[3] ^ p_q.tog_prev;

    // Sample clock watchdog
    if (edge_seen) begin                                         // [R8]
      p_d.idle_cnt    = '0;
      p_d.clk_stopped = 1'b0;
    end else if (p_q.idle_cnt >= STOP_LIMIT) begin
      p_d.clk_stopped = 1'b1;
    end else begin
      p_d.idle_cnt = p_q.idle_cnt + 1'b1;
    end

    // Mode source: the source bit alone decides, no mixing
    pin_mode = adc_ctrl_pkg::decode_mode(p_q.sync2[0],
                                         p_q.sync2[1]);          // [R2]
    reg_mode = adc_ctrl_pkg::decode_mode(p_q.ctrl.out_buf_off_bit,
                                         p_q.ctrl.standby_bit);  // [R2]
    req      = p_q.ctrl.pin_ctrl ? pin_mode : reg_mode;          // [R1] [R17]
    lvds_sel = p_q.ctrl.pin_ctrl ? p_q.sync2[2]
                                 : p_q.ctrl.out_style_bit;       // [R9]
    fmt_sel  = p_q.ctrl.pin_ctrl ? p_q.sync2[2]
                                 : p_q.ctrl.number_format_bit;   // [R16]
    p_d.mode = req;

    sleeping   = (req != adc_ctrl_pkg::PM_NORMAL) || p_q.clk_stopped;
    slow_cause = (req == adc_ctrl_pkg::PM_STANDBY) ||
                 (req == adc_ctrl_pkg::PM_GLOBAL_PD) ||
                 p_q.clk_stopped;

    // Wake sequencing
    case (p_q.wst)
      adc_ctrl_pkg::WS_RUN: begin
        if (sleeping) begin
          p_d.wst       = adc_ctrl_pkg::WS_SLEEP;
          p_d.slow_wake = slow_cause;
        end
      end
      adc_ctrl_pkg::WS_SLEEP: begin
        p_d.slow_wake = p_q.slow_wake | slow_cause;
        if (!sleeping) begin
          p_d.wst = adc_ctrl_pkg::WS_WAKE;
          if (p_q.slow_wake) begin
            p_d.wake_cnt = SLOW_LOAD;                            // [R4] [R6] [R8]
          end else if (lvds_sel) begin
            p_d.wake_cnt = LVDS_LOAD;                            // [R7]
          end else begin
            p_d.wake_cnt = CMOS_LOAD;                            // [R7]
          end
        end
      end
      adc_ctrl_pkg::WS_WAKE: begin
        if (sleeping) begin
          p_d.wst       = adc_ctrl_pkg::WS_SLEEP;
          p_d.slow_wake = slow_cause;
        end else if (p_q.wake_cnt == '0) begin
          p_d.wst = adc_ctrl_pkg::WS_RUN;
        end else begin
          p_d.wake_cnt = p_q.wake_cnt - 1'b1;
        end
      end
      default: begin
        p_d.wst = adc_ctrl_pkg::WS_SLEEP;
      end
    endcase

    // Power and output controls
    p_d.core_pd = slow_cause;                                    // [R3] [R6]
    p_d.ref_pd  = (req == adc_ctrl_pkg::PM_GLOBAL_PD);           // [R3]
    p_d.link.out_en = (req != adc_ctrl_pkg::PM_BUF_OFF) &&
                      (req != adc_ctrl_pkg::PM_GLOBAL_PD);       // [R3] [R7]
    p_d.link.data_valid = (p_d.wst == adc_ctrl_pkg::WS_RUN);     // [R17]
    p_d.link.lvds       = lvds_sel;
    p_d.link.offset_bin = fmt_sel;
    p_d.strobe_delay    = p_q.ctrl.strobe_shift_bit;             // [R12]
    p_d.drive           = p_q.ctrl.drive_boost_field;            // [R13]

    // APB slave, answer in the first access cycle
    setup  = psel && !penable;
    mapped = (paddr == adc_ctrl_pkg::CTRL_OFFS) ||
             (paddr == adc_ctrl_pkg::STATUS_OFFS);
    stat.mode        = p_q.mode;
    stat.lvds_active = p_q.link.lvds;
    stat.waking      = (p_q.wst == adc_ctrl_pkg::WS_WAKE);
    stat.clk_stopped = p_q.clk_stopped;
    stat.data_valid  = p_q.link.data_valid;
    p_d.pready  = setup;
    p_d.pslverr = setup && !mapped;
    p_d.prdata  = '0;
    if (setup && !pwrite) begin
      if (paddr == adc_ctrl_pkg::CTRL_OFFS) begin
        p_d.prdata = {24'h000000, p_q.ctrl};
      end else if (paddr == adc_ctrl_pkg::STATUS_OFFS) begin
        p_d.prdata = {26'h0000000, stat};
      end
    end
    if (psel && penable && p_q.pready && pwrite &&
        (paddr == adc_ctrl_pkg::CTRL_OFFS)) begin
      p_d.ctrl = adc_ctrl_pkg::ctrl_t'(pwdata[7:0]);             // [R1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_q      <= '0;
      p_q.ctrl <= adc_ctrl_pkg::CTRL_RESET;
      p_q.wst  <= adc_ctrl_pkg::WS_SLEEP;
      p_q.slow_wake <= 1'b1;
    end else begin
      p_q <= p_d;
    end
  end

  // ---------------------------------------------------------------
  // Sample-clock next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [11:0] fmt_data;
    logic [11:0] out_data;
    logic [13:0] ddr_word;
    fmt_data = '0;
    out_data = '0;
    ddr_word = '0;
    s_d      = s_q;
    s_d.s1   = p_q.link;
    s_d.s2   = s_q.s1;
    s_d.tog  = ~s_q.tog;

    // Core word is offset binary; twos complement flips the MSB
    fmt_data = s_q.s2.offset_bin ? sample_data_in
             : {~sample_data_in[11], sample_data_in[10:0]};      // [R16]
    out_data = s_q.s2.data_valid ? fmt_data : '0;                // [R17]
    ddr_word = {2'b00, out_data};

    s_d.cmos_data = out_data;                                    // [R10]
    s_d.cmos_oe   = s_q.s2.out_en && !s_q.s2.lvds;               // [R3] [R7]
    s_d.lvds_oe   = s_q.s2.out_en && s_q.s2.lvds;                // [R3] [R7]
    s_d.valid     = s_q.s2.data_valid;

    // Even bit in the high half, odd bit in the low half
    for (int i = 0; i < 7; i++) begin
      cell_rise[i]     = ddr_word[2 * i];                        // [R14] [R15]
      cell_fall[i]     = ddr_word[2 * i + 1];                    // [R15]
      cell_rise[i + 7] = ~ddr_word[2 * i];
      cell_fall[i + 7] = ~ddr_word[2 * i + 1];
    end
    cell_rise[14] = 1'b1;                                        // [R14]
    cell_fall[14] = 1'b0;
    cell_rise[15] = 1'b0;
    cell_fall[15] = 1'b1;
    // CMOS strobe rises mid-word, centred for the receiver
    cell_rise[16] = 1'b0;                                        // [R9] [R11]
    cell_fall[16] = 1'b1;
  end

  always_ff @(posedge sample_clk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Output launch
  // ---------------------------------------------------------------
  ddr_launch_cell #(
    .W (17)
  ) u_launch (
    .clk      (sample_clk),
    .rst_n    (presetn),
    .rise_val (cell_rise),
    .fall_val (cell_fall),
    .pad_out  (cell_out)
  );

  assign lvds_data_p         = cell_out[6:0];
  assign lvds_data_n         = cell_out[13:7];
  assign strobe_out_pos      = cell_out[14];
  assign strobe_out_neg      = cell_out[15];
  assign sample_strobe_out   = cell_out[16];
  assign cmos_data_out       = s_q.cmos_data;
  assign cmos_data_oe        = s_q.cmos_oe;
  assign sample_strobe_oe    = s_q.cmos_oe;
  assign lvds_data_oe        = s_q.lvds_oe;
  assign data_valid_out      = s_q.valid;
  assign prdata              = p_q.prdata;
  assign pready              = p_q.pready;
  assign pslverr             = p_q.pslverr;
  assign core_power_down     = p_q.core_pd;
  assign ref_power_down      = p_q.ref_pd;
  assign strobe_delay_sel    = p_q.strobe_delay;                 // [R12]
  assign cmos_drive_strength = p_q.drive;                        // [R13]

endmodule : adc_powerdown_output_ctrl

/* File: dv/adc_powerdown_output_ctrl_asserts.sv */
`timescale 1ns/1ps

module adc_powerdown_output_ctrl_asserts #(
  parameter int unsigned WAKE_SLOW_CYC_P = 2000
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sample_clk,
  input wire logic [11:0] cmos_data_out,
  input wire logic        cmos_data_oe,
  input wire logic        sample_strobe_oe,
  input wire logic [6:0]  lvds_data_p,
  input wire logic [6:0]  lvds_data_n,
  input wire logic        lvds_data_oe,
  input wire logic        data_valid_out,
  input wire logic        core_power_down,
  input wire logic        ref_power_down,
  input wire logic        strobe_delay_sel,
  input wire logic [1:0]  cmos_drive_strength
);
  localparam int WAKE_MAX = WAKE_SLOW_CYC_P + 40;
  logic [31:0] wd_q;
  // ---------------------------------------------------------------
  // Last control word written
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wd_q <= 32'h0;
    else if (psel && penable && pready && pwrite && paddr == 8'h00)
      wd_q <= pwdata;
  end
  // Cycles since a slow wake began without valid data
  logic wake_arm_q;
  int   wake_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_arm_q <= 1'b0;
      wake_q     <= 0;
    end else begin
      wake_arm_q <= (wake_arm_q || core_power_down) && !data_valid_out;
      wake_q     <= (core_power_down || !wake_arm_q) ? 0 : wake_q + 1;
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_wr_ctrl;
    psel && penable && pready && pwrite && paddr == 8'h00;
  endsequence
  property p_ready;
    @(posedge pclk) disable iff (!presetn) s_setup |=> pready && penable;
  endproperty
  property p_ready_once;
    @(posedge pclk) disable iff (!presetn) pready |=> !pready;
  endproperty
  property p_err;
    @(posedge pclk) disable iff (!presetn)
      pslverr |-> pready && paddr != 8'h00 && paddr != 8'h04;
  endproperty
  property p_rd_idle;
    @(posedge pclk) disable iff (!presetn) !pready |-> prdata == 32'h0;
  endproperty
  property p_ctl_copy;
    @(posedge pclk) disable iff (!presetn) s_wr_ctrl |-> ##2
      strobe_delay_sel == wd_q[5] && cmos_drive_strength == wd_q[7:6];
  endproperty
  property p_pd_tri;
    @(posedge pclk) disable iff (!presetn)
      $rose(ref_power_down) |-> ##[1:20] !cmos_data_oe && !lvds_data_oe;
  endproperty
  property p_ref_core;
    @(posedge pclk) disable iff (!presetn) ref_power_down |-> core_power_down;
  endproperty
  property p_style_excl;
    @(posedge pclk) disable iff (!presetn) !(cmos_data_oe && lvds_data_oe);
  endproperty
  property p_strobe_oe;
    @(posedge pclk) disable iff (!presetn) sample_strobe_oe == cmos_data_oe;
  endproperty
  property p_wake;
    @(posedge pclk) disable iff (!presetn) wake_q < WAKE_MAX;
  endproperty
  property p_lvds_inv;
    @(posedge pclk) disable iff (!presetn)
      lvds_data_oe |-> lvds_data_n == ~lvds_data_p;
  endproperty
  property p_invalid_zero;
    @(posedge sample_clk) disable iff (!presetn)
      !data_valid_out |-> cmos_data_out == 12'h000;
  endproperty
  a_ready:        assert property (p_ready) else $error("no ready");
  a_ready_once:   assert property (p_ready_once) else $error("ready long");
  a_err:          assert property (p_err) else $error("bad error");
  a_rd_idle:      assert property (p_rd_idle) else $error("rdata idle");
  a_ctl_copy:     assert property (p_ctl_copy) else $error("ctl copy");
  a_pd_tri:       assert property (p_pd_tri) else $error("pd drive");
  a_ref_core:     assert property (p_ref_core) else $error("ref core");
  a_style_excl:   assert property (p_style_excl) else $error("two styles");
  a_strobe_oe:    assert property (p_strobe_oe) else $error("strobe oe");
  a_wake:         assert property (p_wake) else $error("slow wake");
  a_lvds_inv:     assert property (p_lvds_inv) else $error("pair skew");
  a_invalid_zero: assert property (p_invalid_zero) else $error("data");
endmodule : adc_powerdown_output_ctrl_asserts

bind adc_powerdown_output_ctrl adc_powerdown_output_ctrl_asserts #(
  .WAKE_SLOW_CYC_P(WAKE_SLOW_CYC_P)
) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sample_clk(sample_clk),
  .cmos_data_out(cmos_data_out), .cmos_data_oe(cmos_data_oe),
  .sample_strobe_oe(sample_strobe_oe), .lvds_data_p(lvds_data_p),
  .lvds_data_n(lvds_data_n), .lvds_data_oe(lvds_data_oe),
  .data_valid_out(data_valid_out), .core_power_down(core_power_down),
  .ref_power_down(ref_power_down), .strobe_delay_sel(strobe_delay_sel),
  .cmos_drive_strength(cmos_drive_strength));

/* File: dv/adc_rx_model.sv */
`timescale 1ns/1ps

module adc_rx_model (
  input  wire logic [11:0] cmos_data_out,
  input  wire logic        sample_strobe_out,
  input  wire logic        sample_strobe_oe,
  input  wire logic [6:0]  lvds_data_p,
  input  wire logic        strobe_out_pos,
  input  wire logic        lvds_data_oe,
  output logic      [11:0] cmos_word,
  output logic      [11:0] lvds_word
);
  logic [6:0] even_q;
  // ---------------------------------------------------------------
  // Capture mid-bit; a released bus reads as all ones
  // ---------------------------------------------------------------
  always @(posedge sample_strobe_out)
    cmos_word <= sample_strobe_oe ? cmos_data_out : 12'hFFF;
  always @(posedge strobe_out_pos) begin
    #16;
    even_q <= lvds_data_p;
  end
  always @(negedge strobe_out_pos) begin
    #16;
    for (int k = 0; k < 6; k++) begin
      lvds_word[2*k]   <= lvds_data_oe ? even_q[k] : 1'b1;
      lvds_word[2*k+1] <= lvds_data_oe ? lvds_data_p[k] : 1'b1;
    end
  end
endmodule : adc_rx_model

/* File: dv/test_adc_powerdown_output_ctrl.sv */
`timescale 1ns/1ps

`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (b)); end end

module test_adc_powerdown_output_ctrl;
  localparam int unsigned WAKE_N = 20;
  localparam logic [11:0] WORD = 12'hA5C;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, sample_clk = 0, sclk_run = 1;
  logic [1:0]  pins = 2'h0, cmos_drive_strength;
  logic iface_sel = 0, cmos_data_oe, sample_strobe_out, sample_strobe_oe;
  logic [11:0] sample_data_in = WORD, cmos_data_out, rx_cmos, rx_lvds;
  logic [6:0]  lvds_data_p, lvds_data_n;
  logic lvds_data_oe, strobe_out_pos, strobe_out_neg, data_valid_out;
  logic core_power_down, ref_power_down, strobe_delay_sel;
  int fails = 0, n_compared = 0, n;

  always #12.5 pclk = ~pclk;
  always begin
    #32;
    if (sclk_run) sample_clk = ~sample_clk;
  end

  adc_powerdown_output_ctrl #(.WAKE_SLOW_CYC_P(WAKE_N)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .buffer_off_pin(pins[1]),
    .sleep_pin(pins[0]), .iface_select_pin(iface_sel),
    .sample_clk(sample_clk), .sample_data_in(sample_data_in),
    .cmos_data_out(cmos_data_out), .cmos_data_oe(cmos_data_oe),
    .sample_strobe_out(sample_strobe_out),
    .sample_strobe_oe(sample_strobe_oe), .lvds_data_p(lvds_data_p),
    .lvds_data_n(lvds_data_n), .lvds_data_oe(lvds_data_oe),
    .strobe_out_pos(strobe_out_pos), .strobe_out_neg(strobe_out_neg),
    .data_valid_out(data_valid_out), .core_power_down(core_power_down),
    .ref_power_down(ref_power_down), .strobe_delay_sel(strobe_delay_sel),
    .cmos_drive_strength(cmos_drive_strength));

  adc_rx_model rx_u (.cmos_data_out(cmos_data_out),
    .sample_strobe_out(sample_strobe_out),
    .sample_strobe_oe(sample_strobe_oe), .lvds_data_p(lvds_data_p),
    .strobe_out_pos(strobe_out_pos), .lvds_data_oe(lvds_data_oe),
    .cmos_word(rx_cmos), .lvds_word(rx_lvds));

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // APB transfer, held until pready
  // ---------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int i;
    i = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin fails++; summarize(); end
  endtask : apb

  task automatic wait_valid();
    n = 0;
    while (data_valid_out !== 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    if (data_valid_out !== 1'b1) begin fails++; summarize(); end
  endtask : wait_valid

  task automatic check_mode(input logic [1:0] m);
    repeat (20) @(posedge pclk);
    apb(0, 8'h04, 32'h0);
    `CHK(rd[5:4], m)
    `CHK(core_power_down, m[0])
    `CHK(ref_power_down, m == 2'h3)
    `CHK(cmos_data_oe | lvds_data_oe, m < 2'h2)
  endtask : check_mode

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    apb(0, 8'h00, 32'h0);
    `CHK(rd, 32'h1)
    apb(0, 8'h08, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
    wait_valid();
    repeat (8) @(posedge sample_clk);
    `CHK(rx_cmos, WORD ^ 12'h800)
    `CHK({cmos_data_oe, lvds_data_oe}, 2'b10)
    iface_sel <= 1;
    repeat (8) @(posedge sample_clk);
    `CHK({rx_lvds, lvds_data_oe}, {WORD, 1'b1})
    `CHK(strobe_out_neg, ~strobe_out_pos)
    iface_sel <= 0;
    $display("test reset_cmos done");
    for (int k = 1; k < 4; k++) begin
      pins <= 2'(k);
      check_mode(2'(k));
      pins <= 2'h0;
      wait_valid();
      `CHK(n <= ((k == 2) ? 8 : WAKE_N) + 20, 1'b1)
    end
    $display("test pin_modes done");
    apb(1, 8'h00, 32'hF8);
    repeat (20) @(posedge pclk);
    `CHK({strobe_delay_sel, cmos_drive_strength}, 3'h7)
    repeat (8) @(posedge sample_clk);
    `CHK(rx_lvds, WORD)
    `CHK({cmos_data_oe, lvds_data_oe}, 2'b01)
    pins <= 2'h3;
    repeat (20) @(posedge pclk);
    `CHK(ref_power_down, 1'b0)
    pins <= 2'h0;
    apb(1, 8'h00, 32'hFA);
    check_mode(2'h1);
    apb(1, 8'h00, 32'hFE);
    check_mode(2'h3);
    apb(1, 8'h04, 32'h0);
    apb(0, 8'h00, 32'h0);
    `CHK({err, rd}, 33'h0_0000_00FE)
    apb(1, 8'h00, 32'h38);
    wait_valid();
    `CHK(n <= WAKE_N + 20, 1'b1)
    repeat (8) @(posedge sample_clk);
    `CHK(rx_lvds, WORD)
    apb(1, 8'h00, 32'h3C);
    check_mode(2'h2);
    apb(1, 8'h00, 32'h38);
    wait_valid();
    `CHK(n <= WAKE_N + 20, 1'b1)
    $display("test register_modes done");
    sclk_run = 0;
    repeat (60) @(posedge pclk);
    apb(0, 8'h04, 32'h0);
    `CHK({rd[1], core_power_down}, 2'b11)
    sclk_run = 1;
    repeat (4) @(posedge sample_clk);
    `CHK(data_valid_out, 1'b0)
    wait_valid();
    `CHK(n <= WAKE_N + 30, 1'b1)
    $display("test clock_stop done");
    summarize();
  end
endmodule : test_adc_powerdown_output_ctrl
